//--- hdl/cfm_params.svh
// constants of the core frame stream mapper
// Function
// RULE1 - app stream packed into 144-byte core frames repeating every 500 us
// RULE2 - 128 application bytes per frame, 16 stuffing bytes of all ones
// RULE3 - time slot 0 may start at any non-stuffing position, no alignment
// RULE4 - application framing loss never resyncs the line; contents pass transparently
// RULE5 - overhead bits nine to forty-eight are unused and sent as ones
// RULE6 - operational only if all pairs active, pair ids correct, no failure
// RULE7 - any pair down or wrong id makes whole section non-operational
// RULE8 - network loop request puts every line transceiver in transparent loopback
// RULE9 - line loopbacks are governed by the management control function
// RULE10 - interface blocks do the remaining time slot 0 maintenance themselves
// RULE11 - core generates line loss indication and active indication
// RULE12 - transceivers ride through 10 ms line interruptions without reset
// RULE13 - stuffing bytes sit at fixed frame positions, every ninth byte
`ifndef CFM_PARAMS_SVH
`define CFM_PARAMS_SVH
`define CFM_PAIRS 3
`define CFM_FRAME_BYTES 144
`define CFM_LAST_POS 8'h8F
`define CFM_STUFF_LAST 4'h8
`define CFM_STUFF_BYTE 8'hFF
`define CFM_OH_UNUSED 40
`define CFM_CLK_NS 20
`define CFM_FRAME_NS 500000
`define CFM_FRAME_CYC (`CFM_FRAME_NS / `CFM_CLK_NS)
`define CFM_MICRO_NS 10000000
`define CFM_RIDE_CYC (`CFM_MICRO_NS / `CFM_CLK_NS)
`define CFM_REG_CTRL 8'h00
`define CFM_REG_STATUS 8'h04
`define CFM_REG_IRQ_STAT 8'h08
`define CFM_REG_IRQ_MASK 8'h0C
`define CFM_CTRL_OM_LOOP 0
`define CFM_CTRL_TX_EN 1
`define CFM_IRQ_DOWN 0
`define CFM_IRQ_LOOP 1
`define CFM_IRQ_OVER 2
`define CFM_IRQ_UNDER 3
`define CFM_IRQ_W 4
`define CFM_CTRL_RESET 2'h2
`endif

//--- hdl/cfm_pkg.sv
// types of the core frame stream mapper
package cfm_pkg;
    typedef struct packed {
        logic valid;
        logic stuff;
        logic [7:0] data;
    } cfm_line_t;
    typedef struct packed {
        logic loop_active;
        logic align_loss;
        logic los_align;
        logic [2:0] pair_ok;
        logic operational;
    } cfm_status_t;
    typedef enum logic [2:0] {
        SECT_DOWN = 3'b001,
        SECT_UP = 3'b010,
        SECT_LOOP = 3'b100
    } cfm_sect_t;
endpackage

//--- hdl/cfm_sync2.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module cfm_sync2 #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

//--- hdl/cfm_ride_through.sv
// per-pair ride-through of short line interruptions
`timescale 1ns/1ps
module cfm_ride_through #(
    parameter int unsigned HOLD = 500000
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // pair activation, synchronised
    input wire logic up,
    // results
    output logic ok,
    output logic reset_req
);
    logic [18:0] cnt;
    logic hit;
    // a gap of exactly HOLD cycles still rides through
    assign hit = (cnt == 19'(HOLD));
    // a gap shorter than HOLD keeps the pair out of reset
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            cnt <= '0;
            ok <= 1'b0;
            reset_req <= 1'b0;
        end else begin
            reset_req <= 1'b0;
            if (up) begin
                cnt <= '0;
                ok <= 1'b1;
            end else if (ok) begin
                cnt <= cnt + 19'h0001;
                if (hit) begin
                    ok <= 1'b0;
                    reset_req <= 1'b1; // RULE12
                    cnt <= '0;
                end
            end
        end
    end
    a_ride_reset: assert property ( // RULE12
        @(posedge core_clk) disable iff (!nrst)
        $rose(reset_req) |-> $past(cnt) == 19'(HOLD) && !$past(up))
        else $error("pair reset before ride-through time");
    a_ride_keep: assert property ( // RULE12
        @(posedge core_clk) disable iff (!nrst)
        up |=> ok && !reset_req)
        else $error("active pair lost ok");
endmodule

//--- hdl/cfm_mapper.sv
// core frame stream mapper top
//
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/1ps
`include "cfm_params.svh"
module cfm_mapper
    import cfm_pkg::*;
#(
    parameter int unsigned FRAME_CYCLES = `CFM_FRAME_CYC,
    parameter int unsigned RIDE_CYCLES = `CFM_RIDE_CYC
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // application stream pins
    input wire logic app_clk,
    input wire logic app_data,
    input wire logic frame_alignment_loss,
    // network side loop request pin
    input wire logic loop_req,
    // line transceiver pair pins
    input wire logic [2:0] pair_active,
    input wire logic [2:0] pair_id_ok,
    input wire logic line_los_align,
    // line byte request from transceiver logic
    input wire logic line_byte_req,
    // line side outputs
    output cfm_line_t line_out,
    output logic line_frame_start,
    output logic [`CFM_OH_UNUSED-1:0] overhead_unused,
    output logic [2:0] pair_loopback,
    output logic [2:0] pair_reset,
    // section state
    output logic section_operational,
    output logic los_align_indication,
    output logic central_end_active_indication,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // interrupt
    output logic irq
);
    logic [1:0] app_s;
    logic app_clk_d;
    logic [2:0] pair_s;
    logic [2:0] id_s;
    logic [2:0] misc_s;
    logic [2:0] pair_ok;
    logic [2:0] ride_rst;
    logic loop_s;
    logic align_s;
    logic los_s;
    logic app_bit_tick;
    logic [7:0] app_shift;
    logic [2:0] app_bits;
    logic [7:0] app_hold;
    logic app_hold_full;
    logic app_byte_done;
    logic [14:0] frame_cnt;
    logic frame_wrap;
    logic [7:0] pos;
    logic [3:0] stuff_cnt;
    logic is_stuff;
    logic [1:0] ctrl;
    logic [`CFM_IRQ_W-1:0] irq_stat;
    logic [`CFM_IRQ_W-1:0] irq_mask;
    logic [`CFM_IRQ_W-1:0] irq_set;
    logic [`CFM_IRQ_W-1:0] irq_clr;
    logic all_good;
    logic loop_want;
    cfm_sect_t sect;
    cfm_sect_t next_sect;
    cfm_status_t status;

    function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off);
        reg_hit = (a == off);
    endfunction

    // pins into the core clock domain
    cfm_sync2 #(.W(2)) u_sync_app (
        .core_clk(core_clk),
        .nrst(nrst),
        .d({app_clk, app_data}),
        .q(app_s)
    );
    cfm_sync2 #(.W(3)) u_sync_pair (
        .core_clk(core_clk),
        .nrst(nrst),
        .d(pair_active),
        .q(pair_s)
    );
    cfm_sync2 #(.W(3)) u_sync_id (
        .core_clk(core_clk),
        .nrst(nrst),
        .d(pair_id_ok),
        .q(id_s)
    );
    cfm_sync2 #(.W(3)) u_sync_misc (
        .core_clk(core_clk),
        .nrst(nrst),
        .d({loop_req, frame_alignment_loss, line_los_align}),
        .q(misc_s)
    );
    assign loop_s = misc_s[2];
    assign align_s = misc_s[1];
    assign los_s = misc_s[0];

    genvar gi;
    generate
        for (gi = 0; gi < `CFM_PAIRS; gi++) begin : g_pair
            cfm_ride_through #(.HOLD(RIDE_CYCLES)) u_ride (
                .core_clk(core_clk),
                .nrst(nrst),
                .up(pair_s[gi]),
                .ok(pair_ok[gi]),
                .reset_req(ride_rst[gi])
            );
        end
    endgenerate
    assign pair_reset = ride_rst;

    // application bit capture on rising app clock, no time slot 0 search
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            app_clk_d <= 1'b0;
        end else begin
            app_clk_d <= app_s[1];
        end
    end
    assign app_bit_tick = app_s[1] && !app_clk_d;

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            app_shift <= 8'h00;
            app_bits <= 3'h0;
            app_byte_done <= 1'b0;
        end else begin
            app_byte_done <= 1'b0;
            if (app_bit_tick) begin
                app_shift <= {app_shift[6:0], app_s[0]};
                app_bits <= app_bits + 3'h1;
                app_byte_done <= (app_bits == 3'h7); // RULE3
            end
        end
    end

    // one byte holding stage between stream and line requests
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            app_hold <= 8'h00;
            app_hold_full <= 1'b0;
        end else begin
            if (app_byte_done) begin
                app_hold <= app_shift; // RULE4
                app_hold_full <= 1'b1;
            end else if (line_byte_req && !is_stuff && !frame_wrap) begin
                app_hold_full <= 1'b0;
            end
        end
    end

    // frame timer, 500 us per core frame
    assign frame_wrap = (frame_cnt == 15'(FRAME_CYCLES - 1));
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            frame_cnt <= 15'h0000;
            line_frame_start <= 1'b0;
        end else begin
            line_frame_start <= frame_wrap; // RULE1
            frame_cnt <= frame_wrap ? 15'h0000 : frame_cnt + 15'h0001;
        end
    end

    // byte position inside the frame, stuffing every ninth byte
    assign is_stuff = (stuff_cnt == 4'h0); // RULE13
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            pos <= 8'h00;
            stuff_cnt <= 4'h0;
        end else if (frame_wrap) begin
            pos <= 8'h00;
            stuff_cnt <= 4'h0;
        end else if (line_byte_req) begin
            pos <= (pos == `CFM_LAST_POS) ? 8'h00 : pos + 8'h01; // RULE1
            stuff_cnt <= (stuff_cnt == `CFM_STUFF_LAST || pos == `CFM_LAST_POS) ?
                4'h0 : stuff_cnt + 4'h1; // RULE2
        end
    end

    // line byte answer; an empty hold sends ones rather than stalling the line
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            line_out <= '0;
        end else begin
            line_out.valid <= line_byte_req;
            line_out.stuff <= line_byte_req && is_stuff;
            if (line_byte_req) begin
                if (is_stuff || !app_hold_full || !ctrl[`CFM_CTRL_TX_EN]) begin
                    line_out.data <= `CFM_STUFF_BYTE; // RULE2
                end else begin
                    line_out.data <= app_hold; // RULE4
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            overhead_unused <= '0;
        end else begin
            overhead_unused <= '1; // RULE5
        end
    end

    // section state
    assign all_good = (&pair_ok) && (&id_s) && !los_s; // RULE6
    assign loop_want = loop_s && ctrl[`CFM_CTRL_OM_LOOP]; // RULE9
    always_comb begin
        next_sect = sect;
        unique case (sect)
            SECT_DOWN: begin
                if (loop_want) next_sect = SECT_LOOP;
                else if (all_good) next_sect = SECT_UP;
            end
            SECT_UP: begin
                if (loop_want) next_sect = SECT_LOOP;
                else if (!all_good) next_sect = SECT_DOWN; // RULE7
            end
            SECT_LOOP: begin
                if (!loop_want) next_sect = SECT_DOWN;
            end
            default: next_sect = SECT_DOWN;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            sect <= SECT_DOWN;
        end else begin
            sect <= next_sect;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            section_operational <= 1'b0;
            los_align_indication <= 1'b0;
            central_end_active_indication <= 1'b0;
            pair_loopback <= 3'h0;
        end else begin
            section_operational <= all_good; // RULE6
            los_align_indication <= los_s; // RULE11
            central_end_active_indication <= all_good; // RULE11
            pair_loopback <= {`CFM_PAIRS{loop_want}}; // RULE8
        end
    end

    // application framing state is only reported, never acted on
    assign status.loop_active = (sect == SECT_LOOP);
    assign status.align_loss = align_s; // RULE10
    assign status.los_align = los_s;
    assign status.pair_ok = pair_ok;
    assign status.operational = section_operational;

    // interrupt sources; set beats a same-cycle clear
    assign irq_set[`CFM_IRQ_DOWN] = (sect == SECT_UP) && (next_sect != SECT_UP);
    assign irq_set[`CFM_IRQ_LOOP] = (sect != SECT_LOOP) && (next_sect == SECT_LOOP);
    assign irq_set[`CFM_IRQ_OVER] = app_byte_done && app_hold_full;
    assign irq_set[`CFM_IRQ_UNDER] = line_byte_req && !is_stuff && !app_hold_full;
    assign irq_clr = (reg_wr && reg_hit(reg_addr, `CFM_REG_IRQ_STAT)) ?
        reg_wdata[`CFM_IRQ_W-1:0] : '0;

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            irq_stat <= '0;
            irq <= 1'b0;
        end else begin
            irq_stat <= (irq_stat & ~irq_clr) | irq_set;
            irq <= |(irq_stat & irq_mask);
        end
    end

    // register writes
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            ctrl <= `CFM_CTRL_RESET;
            irq_mask <= '0;
        end else if (reg_wr) begin
            if (reg_hit(reg_addr, `CFM_REG_CTRL)) ctrl <= reg_wdata[1:0];
            if (reg_hit(reg_addr, `CFM_REG_IRQ_MASK)) irq_mask <= reg_wdata[`CFM_IRQ_W-1:0];
        end
    end

    // register reads, data valid the cycle after the strobe only
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            reg_rdata <= 32'h0000_0000;
        end else begin
            reg_rdata <= 32'h0000_0000;
            if (reg_rd) begin
                if (reg_hit(reg_addr, `CFM_REG_CTRL)) reg_rdata <= 32'(ctrl);
                if (reg_hit(reg_addr, `CFM_REG_STATUS)) reg_rdata <= 32'(status);
                if (reg_hit(reg_addr, `CFM_REG_IRQ_STAT)) reg_rdata <= 32'(irq_stat);
                if (reg_hit(reg_addr, `CFM_REG_IRQ_MASK)) reg_rdata <= 32'(irq_mask);
            end
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);

    a_stuff_ones: assert property ( // RULE2
        line_out.stuff |-> line_out.valid && line_out.data == `CFM_STUFF_BYTE)
        else $error("stuffing byte not all ones");
    a_stuff_place: assert property ( // RULE13
        line_byte_req && is_stuff |=> line_out.stuff)
        else $error("stuffing missing at fixed position");
    a_frame_pos: assert property ( // RULE1
        line_frame_start |-> pos == 8'h00 && is_stuff)
        else $error("frame start without position reset");
    a_pos_wrap: assert property ( // RULE1
        line_byte_req && !frame_wrap && pos == `CFM_LAST_POS |=> pos == 8'h00)
        else $error("frame longer than 144 bytes");
    a_data_pass: assert property ( // RULE4
        line_byte_req && !is_stuff && app_hold_full && ctrl[`CFM_CTRL_TX_EN]
        |=> line_out.data == $past(app_hold))
        else $error("application byte not passed transparently");
    // first edge out of reset still shows the reset value
    a_oh_ones: assert property ( // RULE5
        $past(nrst) |-> overhead_unused == {`CFM_OH_UNUSED{1'b1}})
        else $error("unused overhead bit not one");
    a_oper_cause: assert property ( // RULE6
        section_operational |-> $past(&pair_ok) && $past(&id_s) && !$past(los_s))
        else $error("operational without all conditions");
    a_nonop_any: assert property ( // RULE7
        !(&pair_ok) || !(&id_s) |=> !section_operational)
        else $error("section up with a failed pair");
    a_loop_all: assert property ( // RULE8
        loop_s && ctrl[`CFM_CTRL_OM_LOOP] |=> pair_loopback == {`CFM_PAIRS{1'b1}})
        else $error("loopback not on every pair");
    a_loop_om: assert property ( // RULE9
        pair_loopback != 3'h0 |-> $past(ctrl[`CFM_CTRL_OM_LOOP]))
        else $error("loopback without management enable");
    a_ind_active: assert property ( // RULE11
        central_end_active_indication == section_operational
        && los_align_indication == $past(los_s))
        else $error("indications inconsistent");
    a_irq_level: assert property (irq == $past(|(irq_stat & irq_mask)))
        else $error("interrupt not following status and mask");

    c_frame: cover property (line_frame_start ##1 line_byte_req);
    c_loop: cover property ($rose(pair_loopback[0]));
    c_oper: cover property ($rose(section_operational));
    c_over: cover property (irq_set[2]);
endmodule

//--- testbench/cfm_far_side.sv
// far side model: application stream source and line byte requester
`timescale 1ns/1ps
module cfm_far_side #(
    parameter int unsigned HALF_BIT = 3,
    parameter int unsigned REQ_GAP = 50,
    parameter logic [7:0] PATTERN = 8'h00
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // pins toward the mapper
    output logic app_clk,
    output logic app_data,
    output logic line_byte_req
);
    int unsigned div;
    int unsigned gap;
    logic [2:0] bit_idx;
    // data moves on the falling app clock so the rising edge sees it settled
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            div <= 0;
            app_clk <= 1'b0;
            bit_idx <= 3'h7;
            app_data <= PATTERN[7];
        end else if (div == HALF_BIT - 1) begin
            div <= 0;
            app_clk <= ~app_clk;
            if (app_clk) begin
                app_data <= PATTERN[bit_idx - 3'h1];
                bit_idx <= bit_idx - 3'h1;
            end
        end else begin
            div <= div + 1;
        end
    end
    // paced slower than the byte rate so the hold byte is always fresh
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            gap <= 0;
            line_byte_req <= 1'b0;
        end else begin
            gap <= (gap == REQ_GAP - 1) ? 0 : gap + 1;
            line_byte_req <= (gap == REQ_GAP - 1);
        end
    end
endmodule

//--- testbench/cfm_mapper_bench.sv
// self-checking bench of the core frame stream mapper
`timescale 1ns/1ps
`include "cfm_params.svh"
module cfm_mapper_bench
    import cfm_pkg::*;
;
    localparam int FRAME = 7600;
    localparam int RIDE = 50;
    logic core_clk, nrst, app_clk, app_data, frame_alignment_loss, loop_req;
    logic [2:0] pair_active, pair_id_ok, pair_loopback, pair_reset;
    logic line_los_align, line_byte_req, line_frame_start, section_operational;
    logic los_align_indication, central_end_active_indication, reg_wr, reg_rd, irq;
    cfm_line_t line_out;
    logic [`CFM_OH_UNUSED-1:0] overhead_unused;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    int miscompares = 0;
    int check_count = 0;

    cfm_mapper #(.FRAME_CYCLES(FRAME), .RIDE_CYCLES(RIDE)) u_cfm_mapper (
        .core_clk(core_clk), .nrst(nrst), .app_clk(app_clk), .app_data(app_data),
        .frame_alignment_loss(frame_alignment_loss), .loop_req(loop_req),
        .pair_active(pair_active), .pair_id_ok(pair_id_ok), .line_los_align(line_los_align),
        .line_byte_req(line_byte_req), .line_out(line_out),
        .line_frame_start(line_frame_start), .overhead_unused(overhead_unused),
        .pair_loopback(pair_loopback), .pair_reset(pair_reset),
        .section_operational(section_operational), .los_align_indication(los_align_indication),
        .central_end_active_indication(central_end_active_indication),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .irq(irq));

    cfm_far_side u_cfm_far_side (
        .core_clk(core_clk), .nrst(nrst), .app_clk(app_clk), .app_data(app_data),
        .line_byte_req(line_byte_req));

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    task automatic check(input bit ok, input string msg);
        check_count++;
        if (!ok) begin
            miscompares++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        d = reg_rdata;
    endtask

    // bounded wait for the section state to settle
    task automatic wait_op(input logic v);
        int n;
        n = 0;
        while (section_operational !== v && n < 20) begin
            @(negedge core_clk);
            n++;
        end
    endtask

    task automatic t_reset_values();
        logic [31:0] d;
        reg_read(`CFM_REG_CTRL, d);
        check(d === 32'h0000_0002, "control reset value");
        reg_read(`CFM_REG_IRQ_MASK, d);
        check(d === 32'h0000_0000, "mask reset value");
        reg_write(8'h10, 32'hFFFF_FFFF);
        reg_read(8'h10, d);
        check(d === 32'h0000_0000, "unmapped address");
        check(overhead_unused === {`CFM_OH_UNUSED{1'b1}}, "unused overhead");
        check(pair_loopback === 3'b000, "loop idle");
    endtask

    // one whole frame between two frame starts
    task automatic t_frame(input logic [7:0] exp_data);
        int n, stuffs, cyc, wd;
        n = 0;
        stuffs = 0;
        cyc = 0;
        wd = 0;
        @(negedge core_clk);
        while (line_frame_start !== 1'b1 && wd < FRAME + 10) begin
            @(negedge core_clk);
            wd++;
        end
        do begin
            @(negedge core_clk);
            cyc++;
            if (line_out.valid === 1'b1 && n < 144) begin
                check(line_out.stuff === (n % 9 == 0), "stuffing position");
                check(line_out.data === ((n % 9 == 0) ? 8'hFF : exp_data), "byte");
                stuffs += (line_out.stuff === 1'b1);
                n++;
            end
        end while (line_frame_start !== 1'b1 && cyc < FRAME + 10);
        check(cyc == FRAME, "frame period");
        check(n == 144 && stuffs == 16, "bytes per frame");
    endtask

    task automatic t_section();
        logic [31:0] d;
        bit seen;
        @(posedge core_clk);
        pair_active <= 3'b111;
        pair_id_ok <= 3'b111;
        wait_op(1'b1);
        check(section_operational === 1'b1, "section up");
        check(central_end_active_indication === 1'b1, "active indication");
        reg_read(`CFM_REG_STATUS, d);
        check(d[3:0] === 4'hF, "status up");
        for (int i = 0; i < 3; i++) begin
            @(posedge core_clk);
            pair_id_ok <= 3'b111 & ~(3'b001 << i);
            wait_op(1'b0);
            check(section_operational === 1'b0, "wrong pair id");
            @(posedge core_clk);
            pair_id_ok <= 3'b111;
            wait_op(1'b1);
        end
        @(posedge core_clk);
        line_los_align <= 1'b1;
        wait_op(1'b0);
        check(los_align_indication === 1'b1 && section_operational === 1'b0, "los");
        @(posedge core_clk);
        line_los_align <= 1'b0;
        wait_op(1'b1);
        // a short gap must not reset the pair
        @(posedge core_clk);
        pair_active <= 3'b101;
        repeat (RIDE - 10) begin
            @(negedge core_clk);
            check(pair_reset === 3'b000 && section_operational === 1'b1, "gap");
        end
        @(posedge core_clk);
        pair_active <= 3'b111;
        repeat (10) @(negedge core_clk);
        check(pair_reset === 3'b000 && section_operational === 1'b1, "ride");
        @(posedge core_clk);
        pair_active <= 3'b101;
        seen = 0;
        repeat (RIDE + 20) begin
            @(negedge core_clk);
            seen |= (pair_reset === 3'b010);
        end
        check(seen, "long gap resets pair");
        check(section_operational === 1'b0, "pair down");
        reg_read(`CFM_REG_IRQ_STAT, d);
        check(d[0] === 1'b1 && irq === 1'b0, "down event masked");
        reg_write(`CFM_REG_IRQ_MASK, 32'h0000_0001);
        repeat (3) @(negedge core_clk);
        check(irq === 1'b1, "down irq");
        reg_write(`CFM_REG_IRQ_STAT, 32'h0000_0001);
        repeat (3) @(negedge core_clk);
        check(irq === 1'b0, "irq cleared");
        @(posedge core_clk);
        pair_active <= 3'b111;
        wait_op(1'b1);
    endtask

    task automatic t_loop();
        logic [31:0] d;
        @(posedge core_clk);
        loop_req <= 1'b1;
        repeat (8) @(negedge core_clk);
        check(pair_loopback === 3'b000, "loop refused");
        reg_write(`CFM_REG_CTRL, 32'h0000_0003);
        repeat (4) @(negedge core_clk);
        check(pair_loopback === 3'b111, "loop on all pairs");
        reg_read(`CFM_REG_STATUS, d);
        check(d[6] === 1'b1, "loop status");
        reg_read(`CFM_REG_IRQ_STAT, d);
        check(d[1] === 1'b1, "loop event");
        @(posedge core_clk);
        loop_req <= 1'b0;
        repeat (8) @(negedge core_clk);
        check(pair_loopback === 3'b000, "loop released");
        reg_write(`CFM_REG_CTRL, 32'h0000_0002);
    endtask

    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        repeat (80000) @(posedge core_clk);
        miscompares++;
        $display("wrong value at %0t: watchdog expired", $time);
        report_and_stop();
    end

    initial begin
        logic [31:0] d;
        nrst = 1'b0;
        frame_alignment_loss = 1'b0;
        loop_req = 1'b0;
        pair_active = 3'b000;
        pair_id_ok = 3'b000;
        line_los_align = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (3) @(posedge core_clk);
        nrst <= 1'b1;
        t_reset_values();
        t_frame(8'h00);
        @(posedge core_clk);
        frame_alignment_loss <= 1'b1;
        t_frame(8'h00);
        reg_read(`CFM_REG_STATUS, d);
        check(d[5] === 1'b1, "framing loss shown");
        @(posedge core_clk);
        frame_alignment_loss <= 1'b0;
        reg_write(`CFM_REG_CTRL, 32'h0000_0000);
        t_frame(8'hFF);
        reg_write(`CFM_REG_CTRL, 32'h0000_0002);
        t_section();
        t_loop();
        report_and_stop();
    end
endmodule
